// *** inc/err_pkg.sv ***
// Shared types and constants of the controller error detection logic
package err_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths and codes
	localparam int          WORD_W           = 16;
	localparam int          N_SUM            = 6;
	localparam int          SUM_IW           = 3;
	localparam int          N_SER            = 3;
	localparam logic [15:0] CODE_BUS_FAULT   = 16'h17d7;
	localparam logic [15:0] CODE_SUPPLY_FAIL = 16'h17d8;
	localparam logic [15:0] WORD_RST         = 16'h0000;
	localparam logic        FLAG_RST         = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Summary vector bit positions, lowest position has the lowest number
	localparam int SUM_IO  = 0;
	localparam int SUM_HW  = 1;
	localparam int SUM_PAR = 2;
	localparam int SUM_SYN = 3;
	localparam int SUM_CIR = 4;
	localparam int SUM_OP  = 5;

	// Numbers written to the summary word, indexed by bit position
	localparam logic [N_SUM-1:0][15:0] SUM_NUM = {
		16'h1f83, 16'h1f82, 16'h1f81, 16'h1f80, 16'h1f7d, 16'h1f7c
	};

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic              io_missing;
		logic [15:0]       io_head;
		logic              prog_change;
		logic              param_bad;
		logic              syntax_bad;
		logic              circuit_bad;
		logic              op_err;
		logic [15:0]       op_step;
		logic [N_SER-1:0]  ser_rx;
		logic [N_SER-1:0]  ser_bad;
		logic              usb_rx;
		logic              usb_bad;
		logic              refresh_bad;
		logic              blk_bad;
		logic [15:0]       blk_cond;
		logic              ref_bad;
		logic [31:0]       ref_step;
		logic              buf_init_bad;
		logic              sparam_change;
		logic              sparam_bad;
	} err_evt_t;

	typedef struct packed {
		logic        unit_fault;
		logic        bus_fault;
		logic        supply_lost;
		logic [15:0] supply_io;
	} bus_evt_t;

	typedef struct packed {
		logic io_config_error_flag;
		logic hardware_error_flag;
		logic serial_error_ch0_flag;
		logic serial_error_ch1_flag;
		logic serial_error_ch2_flag;
		logic parameter_error_flag;
		logic syntax_error_flag;
		logic circuit_error_flag;
		logic operation_error_flag;
		logic operation_error_latch_flag;
		logic error_summary_flag;
		logic supply_failure_flag;
		logic unconnected_reference_flag;
		logic output_refresh_error_flag;
		logic buffer_init_failure_flag;
		logic special_block_error_flag;
		logic usb_comm_error_flag;
		logic special_parameter_error_flag;
	} err_flags_t;

	typedef struct packed {
		logic [15:0] error_summary_number;
		logic [15:0] operation_error_latch_word;
		logic [15:0] hardware_error_code_word;
		logic [15:0] supply_failure_io_word;
		logic [15:0] unconnected_head_number;
		logic [15:0] fault_step_low_word;
		logic [15:0] fault_step_high_word;
		logic [15:0] special_block_condition_word;
	} err_words_t;

endpackage : err_pkg

// *** hw/lowest_active.sv ***
// Priority encoder: position of the lowest active bit
`timescale 1ns/1ps

module lowest_active #(
	parameter int N  = 6,
	parameter int IW = 3
) (
	input  wire logic [N-1:0]  active,
	output logic               any,
	output logic [IW-1:0]      index
);

	// Scan from the top so the lowest set bit is written last
	always_comb begin
		any   = 1'b0;
		index = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (active[i]) begin
				any   = 1'b1;
				index = IW'(i);
			end
		end
	end

endmodule : lowest_active

// *** hw/bus_check.sv ***
// Expansion bus check: hardware code word, supply failure and stop request
`timescale 1ns/1ps

module bus_check (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             bus_check_enable,
	input  wire logic             stop_to_run,
	input  wire err_pkg::bus_evt_t bus,
	output logic                  hw_set,
	output logic                  force_stop,
	output logic                  supply_failure_flag,
	output logic [15:0]           hardware_error_code_word,
	output logic [15:0]           supply_failure_io_word
);

	typedef struct packed {
		logic        stop;
		logic        sup;
		logic [15:0] code;
		logic [15:0] sup_word;
	} bc_state_t;

	bc_state_t s_r;
	bc_state_t s_nxt;
	logic      fault_now;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt     = s_r;
		fault_now = bus_check_enable & bus.bus_fault;
		if (fault_now) begin
			s_nxt.code = bus.supply_lost ? err_pkg::CODE_SUPPLY_FAIL
			                             : err_pkg::CODE_BUS_FAULT;
		end
		if (fault_now & bus.supply_lost) begin
			s_nxt.sup_word = bus.supply_io;
		end
		// Follows the stored code, so it trails it by one cycle
		if (s_r.code == err_pkg::CODE_SUPPLY_FAIL) begin
			s_nxt.sup = 1'b1;
		end
		if (stop_to_run) begin
			s_nxt.stop = 1'b0;
		end
		// Set after clear: a failure in the clearing cycle still stops
		if (bus_check_enable & bus.unit_fault) begin
			s_nxt.stop = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hw_set                   = bus_check_enable & (bus.unit_fault | bus.bus_fault);
	assign force_stop               = s_r.stop;
	assign supply_failure_flag      = s_r.sup;
	assign hardware_error_code_word = s_r.code;
	assign supply_failure_io_word   = s_r.sup_word;

	////////////////////////////////////////////////////////////////////////////
	property p_stop;
		@(posedge clock) disable iff (!rst_b)
		bus_check_enable && bus.unit_fault |=> force_stop;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not forced");

	property p_code;
		@(posedge clock) disable iff (!rst_b)
		bus_check_enable && bus.bus_fault |=>
			hardware_error_code_word == ($past(bus.supply_lost)
			? err_pkg::CODE_SUPPLY_FAIL : err_pkg::CODE_BUS_FAULT);
	endproperty
	a_code: assert property (p_code) else $error("wrong code");

	property p_supply;
		@(posedge clock) disable iff (!rst_b)
		hardware_error_code_word == err_pkg::CODE_SUPPLY_FAIL |=> supply_failure_flag;
	endproperty
	a_supply: assert property (p_supply) else $error("supply flag missing");

endmodule : bus_check

// *** hw/controller_error_detection.sv ***
// Error flags, evaluation windows and summary of the controller
`timescale 1ns/1ps

// Functional notes
// - Lowest active major error number goes to summary word; summary flag set.
// - Stop-to-run clears config, hardware, parameter, syntax, circuit, operation flags.
// - Operation latch flag and its word survive stop-to-run.
// - With bus check on, unit failure forces stop, hardware flag.
// - With bus check on, bus fault stores code 6103 or 6104, hardware flag.
// - Code 6104 sets supply failure flag and stores affected I/O numbers.
// - Missing programmed units set config flag and store first missing number.
// - Reference to missing I/O sets flag, stores step as high and low word.
// - Config error checked only at power-on and stop-to-run.
// - Hardware error checked at power-on and always after.
// - Serial flags per channel checked only on reception from the counterpart.
// - Parameter, syntax, circuit checked at power-on, stop-to-run, stopped edits.
// - Operation error and its latch checked during run.
// - Refresh error, special block flag and condition word checked always.
// - Missing-I/O reference checked only during run.
// - Buffer memory init failure checked only at stop-to-run.
// - USB error checked on reception from the counterpart.
// - Special parameter error checked at power-on and stopped parameter changes.
module controller_error_detection (
	input  wire logic               clock,
	input  wire logic               rst_b,
	input  wire logic               run_mode,
	input  wire logic               bus_check_enable,
	input  wire err_pkg::err_evt_t  evt,
	input  wire err_pkg::bus_evt_t  bus,
	output logic                    force_stop,
	output err_pkg::err_flags_t     flags,
	output err_pkg::err_words_t     words
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic                      por_done;
		logic                      run_d;
		logic                      io_cfg;
		logic                      hw;
		logic                      par;
		logic                      syn;
		logic                      cir;
		logic                      op;
		logic                      op_latch;
		logic [err_pkg::N_SER-1:0] ser;
		logic                      refresh;
		logic                      blk;
		logic                      usb;
		logic                      sparam;
		logic                      uref;
		logic                      buf_init;
		logic                      summ;
		logic [15:0]               summ_num;
		logic [15:0]               latch_word;
		logic [15:0]               head;
		logic [15:0]               step_lo;
		logic [15:0]               step_hi;
		logic [15:0]               cond;
	} ctl_state_t;

	ctl_state_t                     s_r;
	ctl_state_t                     s_nxt;
	logic                           power_on;
	logic                           stop_to_run;
	logic                           io_eval;
	logic                           prog_eval;
	logic                           sparam_eval;
	logic                           hw_set;
	logic                           sum_any;
	logic [err_pkg::SUM_IW-1:0]     sum_idx;
	logic [err_pkg::N_SUM-1:0]      sum_vec;
	logic                           supply_flag;
	logic [15:0]                    code_word;
	logic [15:0]                    supply_word;

	////////////////////////////////////////////////////////////////////////////
	// Evaluation windows

	// Power-on is the first cycle after reset release
	assign power_on    = ~s_r.por_done;
	// Gated by por_done so a controller already in run at power-on is no transition
	assign stop_to_run = run_mode & ~s_r.run_d & s_r.por_done;
	assign io_eval     = power_on | stop_to_run;
	assign prog_eval   = power_on | stop_to_run | (~run_mode & evt.prog_change);
	assign sparam_eval = power_on | (~run_mode & evt.sparam_change);

	////////////////////////////////////////////////////////////////////////////
	// Summary source, taken from the registered flags

	always_comb begin
		sum_vec                   = '0;
		sum_vec[err_pkg::SUM_IO]  = s_r.io_cfg;
		sum_vec[err_pkg::SUM_HW]  = s_r.hw;
		sum_vec[err_pkg::SUM_PAR] = s_r.par;
		sum_vec[err_pkg::SUM_SYN] = s_r.syn;
		sum_vec[err_pkg::SUM_CIR] = s_r.cir;
		sum_vec[err_pkg::SUM_OP]  = s_r.op;
	end

	lowest_active #(
		.N  (err_pkg::N_SUM),
		.IW (err_pkg::SUM_IW)
	) u_lowest (
		.active (sum_vec),
		.any    (sum_any),
		.index  (sum_idx)
	);

	bus_check u_bus (
		.clock                    (clock),
		.rst_b                    (rst_b),
		.bus_check_enable         (bus_check_enable),
		.stop_to_run              (stop_to_run),
		.bus                      (bus),
		.hw_set                   (hw_set),
		.force_stop               (force_stop),
		.supply_failure_flag      (supply_flag),
		.hardware_error_code_word (code_word),
		.supply_failure_io_word   (supply_word)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state; every clear comes before the sets so a set wins

	always_comb begin
		s_nxt          = s_r;
		s_nxt.por_done = 1'b1;
		s_nxt.run_d    = run_mode;
		if (stop_to_run) begin
			s_nxt.io_cfg = 1'b0;
			s_nxt.hw     = 1'b0;
			s_nxt.par    = 1'b0;
			s_nxt.syn    = 1'b0;
			s_nxt.cir    = 1'b0;
			s_nxt.op     = 1'b0;
		end
		if (io_eval & evt.io_missing) begin
			s_nxt.io_cfg = 1'b1;
			s_nxt.head   = evt.io_head;
		end
		// Bus check runs every cycle from power-on on
		if (hw_set) begin
			s_nxt.hw = 1'b1;
		end
		for (int i = 0; i < err_pkg::N_SER; i++) begin
			if (evt.ser_rx[i] & evt.ser_bad[i]) begin
				s_nxt.ser[i] = 1'b1;
			end
		end
		if (prog_eval) begin
			s_nxt.par = s_nxt.par | evt.param_bad;
			s_nxt.syn = s_nxt.syn | evt.syntax_bad;
			s_nxt.cir = s_nxt.cir | evt.circuit_bad;
		end
		if (run_mode & evt.op_err) begin
			s_nxt.op       = 1'b1;
			s_nxt.op_latch = 1'b1;
			// The latch keeps the first failing step only
			if (!s_r.op_latch) begin
				s_nxt.latch_word = evt.op_step;
			end
		end
		s_nxt.refresh = s_r.refresh | evt.refresh_bad;
		s_nxt.blk     = s_r.blk | evt.blk_bad;
		s_nxt.cond    = evt.blk_cond;
		if (run_mode & evt.ref_bad) begin
			s_nxt.uref    = 1'b1;
			s_nxt.step_lo = evt.ref_step[15:0];
			s_nxt.step_hi = evt.ref_step[31:16];
		end
		if (stop_to_run & evt.buf_init_bad) begin
			s_nxt.buf_init = 1'b1;
		end
		if (evt.usb_rx & evt.usb_bad) begin
			s_nxt.usb = 1'b1;
		end
		if (sparam_eval & evt.sparam_bad) begin
			s_nxt.sparam = 1'b1;
		end
		// Summary trails the flags by one cycle
		s_nxt.summ     = sum_any;
		s_nxt.summ_num = sum_any ? err_pkg::SUM_NUM[sum_idx] : err_pkg::WORD_RST;
	end

	// Only reset clears the remaining flags except the summary, so tools can still see them
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		flags.io_config_error_flag         = s_r.io_cfg;
		flags.hardware_error_flag          = s_r.hw;
		flags.serial_error_ch0_flag        = s_r.ser[0];
		flags.serial_error_ch1_flag        = s_r.ser[1];
		flags.serial_error_ch2_flag        = s_r.ser[2];
		flags.parameter_error_flag         = s_r.par;
		flags.syntax_error_flag            = s_r.syn;
		flags.circuit_error_flag           = s_r.cir;
		flags.operation_error_flag         = s_r.op;
		flags.operation_error_latch_flag   = s_r.op_latch;
		flags.error_summary_flag           = s_r.summ;
		flags.supply_failure_flag          = supply_flag;
		flags.unconnected_reference_flag   = s_r.uref;
		flags.output_refresh_error_flag    = s_r.refresh;
		flags.buffer_init_failure_flag     = s_r.buf_init;
		flags.special_block_error_flag     = s_r.blk;
		flags.usb_comm_error_flag          = s_r.usb;
		flags.special_parameter_error_flag = s_r.sparam;
		words.error_summary_number         = s_r.summ_num;
		words.operation_error_latch_word   = s_r.latch_word;
		words.hardware_error_code_word     = code_word;
		words.supply_failure_io_word       = supply_word;
		words.unconnected_head_number      = s_r.head;
		words.fault_step_low_word          = s_r.step_lo;
		words.fault_step_high_word         = s_r.step_hi;
		words.special_block_condition_word = s_r.cond;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_summary;
		@(posedge clock) disable iff (!rst_b)
		s_r.io_cfg |=> flags.error_summary_flag
			&& words.error_summary_number == err_pkg::SUM_NUM[err_pkg::SUM_IO];
	endproperty
	a_summary: assert property (p_summary) else $error("summary wrong");

	property p_clear;
		@(posedge clock) disable iff (!rst_b)
		stop_to_run && !evt.io_missing && !hw_set |=>
			!flags.io_config_error_flag && !flags.hardware_error_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared");

	property p_latch_keep;
		@(posedge clock) disable iff (!rst_b)
		stop_to_run && s_r.op_latch |=> s_r.op_latch && $stable(s_r.latch_word);
	endproperty
	a_latch_keep: assert property (p_latch_keep) else $error("latch lost");

	property p_hw_flag;
		@(posedge clock) disable iff (!rst_b)
		bus_check_enable && bus.unit_fault |=> flags.hardware_error_flag ##1 flags.error_summary_flag;
	endproperty
	a_hw_flag: assert property (p_hw_flag) else $error("hardware flag missing");

	property p_head;
		@(posedge clock) disable iff (!rst_b)
		io_eval && evt.io_missing |=>
			flags.io_config_error_flag && words.unconnected_head_number == $past(evt.io_head);
	endproperty
	a_head: assert property (p_head) else $error("head number wrong");

	property p_step;
		@(posedge clock) disable iff (!rst_b)
		run_mode && evt.ref_bad |=> flags.unconnected_reference_flag
			&& {words.fault_step_high_word, words.fault_step_low_word} == $past(evt.ref_step);
	endproperty
	a_step: assert property (p_step) else $error("step words wrong");

	property p_io_window;
		@(posedge clock) disable iff (!rst_b)
		!io_eval && !s_r.io_cfg |=> !s_r.io_cfg;
	endproperty
	a_io_window: assert property (p_io_window) else $error("config set outside window");

	property p_serial;
		@(posedge clock) disable iff (!rst_b)
		!evt.ser_rx[0] && !s_r.ser[0] |=> !flags.serial_error_ch0_flag;
	endproperty
	a_serial: assert property (p_serial) else $error("serial flag without reception");

	property p_prog;
		@(posedge clock) disable iff (!rst_b)
		prog_eval && evt.syntax_bad |=> flags.syntax_error_flag;
	endproperty
	a_prog: assert property (p_prog) else $error("syntax flag missing");

	property p_op_run;
		@(posedge clock) disable iff (!rst_b)
		!run_mode && !s_r.op_latch |=> !s_r.op_latch;
	endproperty
	a_op_run: assert property (p_op_run) else $error("latch set while stopped");

	property p_cond;
		@(posedge clock) disable iff (!rst_b)
		evt.blk_bad |=> flags.special_block_error_flag
			&& words.special_block_condition_word == $past(evt.blk_cond);
	endproperty
	a_cond: assert property (p_cond) else $error("special block not tracked");

	property p_buf;
		@(posedge clock) disable iff (!rst_b)
		!stop_to_run && !s_r.buf_init |=> !flags.buffer_init_failure_flag;
	endproperty
	a_buf: assert property (p_buf) else $error("init failure outside window");

	property p_sparam;
		@(posedge clock) disable iff (!rst_b)
		run_mode && s_r.por_done && !s_r.sparam |=> !flags.special_parameter_error_flag;
	endproperty
	a_sparam: assert property (p_sparam) else $error("special parameter set in run");

	property p_sticky;
		@(posedge clock) disable iff (!rst_b)
		flags.usb_comm_error_flag |=> flags.usb_comm_error_flag [*3];
	endproperty
	a_sticky: assert property (p_sticky) else $error("usb flag dropped");

	property p_hw_eval;
		@(posedge clock) disable iff (!rst_b)
		hw_set |=> flags.hardware_error_flag;
	endproperty
	a_hw_eval: assert property (p_hw_eval) else $error("hardware flag not set");

	property p_op_clear;
		@(posedge clock) disable iff (!rst_b)
		stop_to_run && !evt.op_err && !evt.syntax_bad |=>
			!flags.operation_error_flag && !flags.syntax_error_flag;
	endproperty
	a_op_clear: assert property (p_op_clear) else $error("operation flags not cleared");

	property p_ref_run;
		@(posedge clock) disable iff (!rst_b)
		!run_mode && !s_r.uref |=> !flags.unconnected_reference_flag;
	endproperty
	a_ref_run: assert property (p_ref_run) else $error("reference flag set while stopped");

	property p_usb_rx;
		@(posedge clock) disable iff (!rst_b)
		!evt.usb_rx && !s_r.usb |=> !flags.usb_comm_error_flag;
	endproperty
	a_usb_rx: assert property (p_usb_rx) else $error("usb flag without reception");

endmodule : controller_error_detection

// *** verification/expansion_bus_model.sv ***
// Behavioural model of the expansion units and supply units on the I/O bus
`timescale 1ns/1ps

module expansion_bus_model #(
	parameter logic [15:0] SUPPLY_IO = 16'h0040
) (
	input  wire logic [1:0]        fault_sel,
	output err_pkg::bus_evt_t      bus
);
	////////////////////////////////////////////////////////////////////////////
	// 0 healthy, 1 unit failure, 2 bus fault, 3 bus fault with 24 V lost
	always_comb begin
		bus             = '0;
		bus.unit_fault  = (fault_sel == 2'h1);
		bus.bus_fault   = fault_sel[1];
		bus.supply_lost = (fault_sel == 2'h3);
		// Other selections show the inverted SUPPLY_IO, never the failure number
		bus.supply_io   = (fault_sel == 2'h3) ? SUPPLY_IO : ~SUPPLY_IO;
	end
endmodule : expansion_bus_model

// *** verification/tb_controller_error_detection.sv ***
// Self-checking bench of the controller error detection block
`timescale 1ns/1ps

module tb_controller_error_detection;
	logic                clock;
	logic                rst_b;
	logic                run_mode;
	logic                bus_check_enable;
	logic [1:0]          fault_sel;
	err_pkg::err_evt_t   evt;
	err_pkg::bus_evt_t   bus;
	logic                force_stop;
	err_pkg::err_flags_t flags;
	err_pkg::err_words_t words;
	int                  n_mismatch;
	int                  checks;
	int                  cycles;

	////////////////////////////////////////////////////////////////////////////
	expansion_bus_model i_bus (.fault_sel(fault_sel), .bus(bus));

	controller_error_detection i_dut (
		.clock(clock), .rst_b(rst_b), .run_mode(run_mode),
		.bus_check_enable(bus_check_enable), .evt(evt), .bus(bus),
		.force_stop(force_stop), .flags(flags), .words(words)
	);

	always #5 clock = ~clock;

	// Whole run is about 40 cycles; a hang is cut at cycle 2000
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			n_mismatch++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	task automatic cmp_flag(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : cmp_flag

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp_word

	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////
	task automatic t_power_on();
		repeat (5) @(posedge clock);
		#1;
		rst_b = 1'b1;
		step(1);
		evt.io_missing = 1'b0;
		cmp_flag(flags.io_config_error_flag, 1'b1, "config flag");
		cmp_word(words.unconnected_head_number, 16'h1020, "head number");
		step(1);
		cmp_flag(flags.error_summary_flag, 1'b1, "summary flag");
		cmp_word(words.error_summary_number, 16'h1f7c, "summary num");
		$display("test power_on done");
	endtask : t_power_on

	task automatic t_stop_to_run();
		run_mode = 1'b1;
		step(1);
		cmp_flag(flags.io_config_error_flag, 1'b0, "config cleared");
		step(1);
		cmp_flag(flags.error_summary_flag, 1'b0, "summary off");
		cmp_word(words.error_summary_number, 16'h0000, "summary zero");
		evt.io_missing = 1'b1;
		evt.param_bad  = 1'b1;
		step(2);
		cmp_flag(flags.io_config_error_flag, 1'b0, "config in run");
		cmp_flag(flags.parameter_error_flag, 1'b0, "param in run");
		evt.io_missing = 1'b0;
		evt.param_bad  = 1'b0;
		evt.op_err     = 1'b1;
		evt.op_step    = 16'h0123;
		step(1);
		evt.op_err = 1'b0;
		cmp_flag(flags.operation_error_flag, 1'b1, "op flag");
		cmp_flag(flags.operation_error_latch_flag, 1'b1, "op latch");
		step(1);
		cmp_word(words.error_summary_number, 16'h1f83, "summary op");
		run_mode     = 1'b0;
		evt.ref_bad  = 1'b1;
		evt.ref_step = 32'h0001_0002;
		step(1);
		cmp_flag(flags.unconnected_reference_flag, 1'b0, "ref stopped");
		run_mode = 1'b1;
		step(1);
		evt.ref_bad = 1'b0;
		cmp_flag(flags.operation_error_flag, 1'b0, "op cleared");
		cmp_flag(flags.operation_error_latch_flag, 1'b1, "latch kept");
		cmp_word(words.operation_error_latch_word, 16'h0123, "latch word");
		cmp_flag(flags.unconnected_reference_flag, 1'b1, "ref run");
		cmp_word(words.fault_step_high_word, 16'h0001, "step high");
		cmp_word(words.fault_step_low_word, 16'h0002, "step low");
		$display("test stop_to_run done");
	endtask : t_stop_to_run

	task automatic t_stopped_edits();
		run_mode = 1'b0;
		{evt.param_bad, evt.syntax_bad, evt.circuit_bad, evt.sparam_bad} = 4'hf;
		step(1);
		cmp_word({flags.parameter_error_flag, flags.syntax_error_flag,
			flags.circuit_error_flag, flags.special_parameter_error_flag}, 4'h0, "no edit");
		evt.prog_change   = 1'b1;
		evt.sparam_change = 1'b1;
		step(1);
		{evt.prog_change, evt.sparam_change} = 2'h0;
		{evt.param_bad, evt.syntax_bad, evt.circuit_bad, evt.sparam_bad} = 4'h0;
		cmp_word({flags.parameter_error_flag, flags.syntax_error_flag,
			flags.circuit_error_flag}, 3'h7, "edit checks");
		cmp_flag(flags.special_parameter_error_flag, 1'b1, "sparam");
		step(1);
		cmp_word(words.error_summary_number, 16'h1f80, "summary param");
		step(3);
		cmp_flag(flags.syntax_error_flag, 1'b1, "syntax held");
		$display("test stopped_edits done");
	endtask : t_stopped_edits

	task automatic t_transition();
		evt.buf_init_bad = 1'b1;
		step(1);
		cmp_flag(flags.buffer_init_failure_flag, 1'b0, "buf stopped");
		evt.param_bad = 1'b1;
		run_mode      = 1'b1;
		step(1);
		{evt.buf_init_bad, evt.param_bad} = 2'h0;
		cmp_flag(flags.buffer_init_failure_flag, 1'b1, "buf at run");
		cmp_flag(flags.parameter_error_flag, 1'b1, "param at run");
		cmp_flag(flags.syntax_error_flag, 1'b0, "syntax cleared");
		$display("test transition done");
	endtask : t_transition

	task automatic t_receive();
		evt.ser_bad = 3'h7;
		evt.usb_bad = 1'b1;
		step(2);
		cmp_flag(flags.usb_comm_error_flag, 1'b0, "usb idle");
		for (int i = 0; i < 3; i++) begin
			evt.ser_rx = 3'h1 << i;
			step(1);
			cmp_word({flags.serial_error_ch2_flag, flags.serial_error_ch1_flag,
				flags.serial_error_ch0_flag}, (32'h2 << i) - 32'h1, "serial");
		end
		evt.ser_rx = 3'h0;
		evt.usb_rx = 1'b1;
		step(1);
		evt.usb_rx = 1'b0;
		cmp_flag(flags.usb_comm_error_flag, 1'b1, "usb rx");
		$display("test receive done");
	endtask : t_receive

	task automatic t_always();
		run_mode        = 1'b0;
		evt.refresh_bad = 1'b1;
		evt.blk_bad     = 1'b1;
		evt.blk_cond    = 16'h00a5;
		step(1);
		cmp_flag(flags.output_refresh_error_flag, 1'b1, "refresh");
		cmp_flag(flags.special_block_error_flag, 1'b1, "block");
		cmp_word(words.special_block_condition_word, 16'h00a5, "cond");
		evt.blk_cond = 16'h005a;
		step(1);
		cmp_word(words.special_block_condition_word, 16'h005a, "cond new");
		$display("test always done");
	endtask : t_always

	task automatic t_bus();
		fault_sel = 2'h3;
		step(2);
		cmp_flag(flags.hardware_error_flag, 1'b0, "bus off");
		cmp_flag(force_stop, 1'b0, "no stop");
		bus_check_enable = 1'b1;
		fault_sel        = 2'h1;
		step(1);
		cmp_flag(force_stop, 1'b1, "unit stop");
		cmp_flag(flags.hardware_error_flag, 1'b1, "unit hw");
		fault_sel = 2'h2;
		step(1);
		cmp_word(words.hardware_error_code_word, 16'h17d7, "code 6103");
		fault_sel = 2'h3;
		step(1);
		fault_sel = 2'h0;
		cmp_word(words.hardware_error_code_word, 16'h17d8, "code 6104");
		cmp_word(words.supply_failure_io_word, 16'h0040, "supply io");
		step(1);
		cmp_flag(flags.supply_failure_flag, 1'b1, "supply flag");
		cmp_word(words.error_summary_number, 16'h1f7d, "summary hw");
		run_mode = 1'b1;
		step(1);
		cmp_flag(flags.hardware_error_flag, 1'b0, "hw cleared");
		cmp_flag(flags.supply_failure_flag, 1'b1, "supply kept");
		cmp_flag(force_stop, 1'b0, "stop released");
		fault_sel = 2'h2;
		step(1);
		fault_sel = 2'h0;
		cmp_flag(flags.hardware_error_flag, 1'b1, "hw in run");
		$display("test bus done");
	endtask : t_bus

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clock            = 1'b0;
		rst_b            = 1'b0;
		run_mode         = 1'b0;
		bus_check_enable = 1'b0;
		fault_sel        = 2'h0;
		evt              = '0;
		evt.io_missing   = 1'b1;
		evt.io_head      = 16'h1020;
		n_mismatch       = 0;
		checks           = 0;
		cycles           = 0;
		t_power_on();
		t_stop_to_run();
		t_stopped_edits();
		t_transition();
		t_receive();
		t_always();
		t_bus();
		results();
	end
endmodule : tb_controller_error_detection
